// ### core/smhf_pkg.sv
// Shared constants and types of the satellite message header framer.
package smhf_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int LEN_W = 16;
  localparam int DEC_DIGITS = 5;
  localparam int NAME_MAX = 8;
  localparam int PKT_MAX_DEF = 64;
  localparam logic [6:0] ID_LAST = 7'h63;
  // ----------------------------------------------------------------
  // Header codes and sub-header characters
  // ----------------------------------------------------------------
  localparam logic [7:0] HC_SELF = 8'h30;
  localparam logic [7:0] HC_ALARM_IN = 8'h32;
  localparam logic [7:0] HC_ALARM_OUT = 8'h34;
  localparam logic [7:0] HC_CMD = 8'h36;
  localparam logic [7:0] HC_FORCED = 8'h38;
  localparam logic [7:0] HC_USER = 8'h7d;
  localparam logic [7:0] HC_ESC = 8'h7e;
  localparam logic [7:0] HC_BINARY = 8'hff;
  localparam logic [7:0] HC_PRINT_LO = 8'h20;
  localparam logic [7:0] HC_PRINT_HI = 8'h7e;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_NAME_TAG = 8'h4e;
  localparam logic [7:0] CH_EQUALS = 8'h3d;
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_SELF = 3'b000, K_ALARM_IN = 3'b001, K_ALARM_OUT = 3'b010, K_CMD = 3'b011,
    K_FORCED = 3'b100, K_USER = 3'b101, K_ESC = 3'b110
  } smhf_kind_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_HDR = 3'b001, S_ESC = 3'b010, S_SUB = 3'b011,
    S_DATA = 3'b100, S_DONE = 3'b101
  } smhf_state_e;
  typedef enum logic [2:0] {
    F_ID = 3'b000, F_OFF = 3'b001, F_TOT = 3'b010, F_NAME = 3'b011, F_COLON = 3'b100
  } smhf_field_e;

  // Extended variants are the base digit plus one; user and escape never extend.
  function automatic logic [7:0] smhf_hdr_code(smhf_kind_e k, logic ext);
    logic [7:0] base;
    case (k)
      K_ALARM_IN: base = HC_ALARM_IN;
      K_ALARM_OUT: base = HC_ALARM_OUT;
      K_CMD: base = HC_CMD;
      K_FORCED: base = HC_FORCED;
      K_USER: base = HC_USER;
      K_ESC: base = HC_ESC;
      default: base = HC_SELF;
    endcase
    if (k == K_USER || k == K_ESC) begin
      return base;
    end
    return base | {7'h00, ext};
  endfunction
endpackage

// ### core/smhf_dec.sv
// Binary to decimal ASCII digit converter for sub-header number fields.
`timescale 1ns/100ps
module smhf_dec #(
  parameter int WIDTH = smhf_pkg::LEN_W,
  parameter int DIGITS = smhf_pkg::DEC_DIGITS
) (
  // Value in
  input wire logic [WIDTH-1:0] value,
  // Digits out, least significant at bits 7:0
  output logic [8*DIGITS-1:0] ascii,
  output logic [2:0] msd
);
  import smhf_pkg::*;

  logic [4*DIGITS-1:0] bcd;

  // Double dabble; purely combinational, one conversion per field.
  always_comb begin
    bcd = '0;
    for (int b = WIDTH - 1; b >= 0; b--) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (bcd[4*d+:4] > 4'h4) begin
          bcd[4*d+:4] = bcd[4*d+:4] + 4'h3;
        end
      end
      bcd = {bcd[4*DIGITS-2:0], value[b]};
    end
  end

  always_comb begin
    msd = 3'h0;
    for (int d = 0; d < DIGITS; d++) begin
      ascii[8*d+:8] = {4'h3, bcd[4*d+:4]};
      if (bcd[4*d+:4] != 4'h0) begin
        msd = 3'(d);
      end
    end
  end
endmodule

// ### core/smhf_ctx.sv
// Context of one message in flight: id, kind, length and progress.
`timescale 1ns/100ps
module smhf_ctx #(
  parameter int PKT_MAX = smhf_pkg::PKT_MAX_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // New message
  input wire logic start,
  input wire smhf_pkg::smhf_kind_e start_kind,
  input wire logic [smhf_pkg::LEN_W-1:0] start_total,
  input wire logic start_name_en,
  input wire logic [7:0] start_esc,
  input wire logic [6:0] start_id,
  // Packet finished
  input wire logic adv,
  // Context state
  output logic active,
  output smhf_pkg::smhf_kind_e kind,
  output logic [smhf_pkg::LEN_W-1:0] total,
  output logic [smhf_pkg::LEN_W-1:0] offset,
  output logic name_en,
  output logic [7:0] esc,
  output logic [6:0] id,
  output logic [smhf_pkg::LEN_W-1:0] chunk,
  output logic ext
);
  import smhf_pkg::*;

  logic [LEN_W-1:0] rem;

  assign rem = total - offset;
  assign chunk = (rem > LEN_W'(PKT_MAX)) ? LEN_W'(PKT_MAX) : rem;
  assign ext = total > LEN_W'(PKT_MAX);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      kind <= K_SELF;
      total <= '0;
      offset <= '0;
      name_en <= 1'b0;
      esc <= 8'h00;
      id <= 7'h00;
    end else if (start && !active) begin
      active <= 1'b1;
      kind <= start_kind;
      total <= start_total;
      offset <= '0;
      name_en <= start_name_en;
      esc <= start_esc;
      id <= start_id;
    end else if (adv) begin
      // Offsets only grow, so packets of one message leave in order.
      offset <= offset + chunk;
      if (rem <= chunk) begin
        active <= 1'b0;
      end
    end
  end
endmodule

// ### core/smhf_framer.sv
// Packet framer: type byte, optional sub-header and payload per modem packet.
// Behaviour
// - Each packet starts with one printable ASCII type byte.
// - Type digits 0x30..0x38 by message kind; plus one marks extended.
// - 0x7D is user defined; 0x7E escapes, next byte gives meaning.
// - Type byte 0xFF is reserved and never produced.
// - Messages longer than one packet use the extended type, except user and escape.
// - Extended packets carry a comma-separated sub-header after the type.
// - First sub-header has id, offset, total; later ones id, offset.
// - Message id is decimal text, counts from 0, wraps after 99.
// - Total count is decimal text of payload bytes only.
// - Offset is decimal text, zero-based position of first payload byte.
// - Station-name option forces a sub-header even on single packets.
// - Station name follows total as comma, N, equals, name.
// - Command responses go out at once, between other message packets.
// - Packets of one message leave in ascending offset order.
`timescale 1ns/100ps
module smhf_framer #(
  parameter int PKT_MAX = smhf_pkg::PKT_MAX_DEF,
  parameter int NAME_MAX = smhf_pkg::NAME_MAX
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Message requests
  input wire logic msg_start,
  input wire smhf_pkg::smhf_kind_e msg_kind,
  input wire logic [smhf_pkg::LEN_W-1:0] msg_total,
  input wire logic msg_name_en,
  input wire logic [7:0] msg_esc,
  output logic norm_busy,
  output logic cmd_busy,
  // Station name, first character at bits 7:0
  input wire logic [8*NAME_MAX-1:0] station_name,
  input wire logic [3:0] station_name_len,
  // Payload of reports
  input wire logic [7:0] norm_data,
  input wire logic norm_valid,
  output logic norm_ready,
  // Payload of command responses
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  // Packet stream to the modem buffer
  output logic [7:0] out_data,
  output logic out_valid,
  output logic out_last,
  input wire logic out_ready
);
  import smhf_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smhf_state_e st_reg;
  smhf_field_e fld_reg, fld_next;
  logic sel_cmd_reg, ov_reg, ol_reg, hdr_reg, nrdy_reg, crdy_reg;
  logic [7:0] od_reg;
  logic [3:0] ci_reg, ci_next;
  logic [2:0] dpos_reg, dpos_next, dec_msd, name_idx;
  logic [6:0] id_ctr_reg;
  logic [LEN_W-1:0] rem_reg, dec_val;
  logic [8*DEC_DIGITS-1:0] dec_ascii;
  logic [7:0] sub_char, src_byte;
  logic sub_end, free, src_take, adv, norm_start, cmd_start, msg_acc, sub_on;
  logic norm_active, cmd_active, norm_name, cmd_name, norm_ext, cmd_ext;
  smhf_kind_e norm_kind, cmd_kind, c_kind;
  logic [LEN_W-1:0] norm_total, cmd_total, norm_off, cmd_off, norm_chunk, cmd_chunk;
  logic [LEN_W-1:0] c_total, c_off, c_chunk;
  logic [7:0] norm_esc, cmd_esc, c_esc;
  logic [6:0] norm_id, cmd_id, c_id;
  logic c_name, c_ext;

  // ----------------------------------------------------------------
  // Message contexts and id counter
  // ----------------------------------------------------------------
  // Command responses get their own context so they never wait for a report.
  assign cmd_start = msg_start && (msg_kind == K_CMD);
  assign norm_start = msg_start && (msg_kind != K_CMD);
  assign msg_acc = (cmd_start && !cmd_active) || (norm_start && !norm_active);
  assign adv = (st_reg == S_DONE);

  smhf_ctx #(.PKT_MAX(PKT_MAX)) u_norm (
    .clock(clock), .rst_n(rst_n), .start(norm_start), .start_kind(msg_kind),
    .start_total(msg_total), .start_name_en(msg_name_en), .start_esc(msg_esc),
    .start_id(id_ctr_reg), .adv(adv && !sel_cmd_reg), .active(norm_active),
    .kind(norm_kind), .total(norm_total), .offset(norm_off), .name_en(norm_name),
    .esc(norm_esc), .id(norm_id), .chunk(norm_chunk), .ext(norm_ext)
  );

  smhf_ctx #(.PKT_MAX(PKT_MAX)) u_cmd (
    .clock(clock), .rst_n(rst_n), .start(cmd_start), .start_kind(msg_kind),
    .start_total(msg_total), .start_name_en(msg_name_en), .start_esc(msg_esc),
    .start_id(id_ctr_reg), .adv(adv && sel_cmd_reg), .active(cmd_active),
    .kind(cmd_kind), .total(cmd_total), .offset(cmd_off), .name_en(cmd_name),
    .esc(cmd_esc), .id(cmd_id), .chunk(cmd_chunk), .ext(cmd_ext)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_ctr_reg <= 7'h00;
    end else if (msg_acc) begin
      id_ctr_reg <= (id_ctr_reg == ID_LAST) ? 7'h00 : id_ctr_reg + 7'h01;
    end
  end

  assign c_kind = sel_cmd_reg ? cmd_kind : norm_kind;
  assign c_total = sel_cmd_reg ? cmd_total : norm_total;
  assign c_off = sel_cmd_reg ? cmd_off : norm_off;
  assign c_chunk = sel_cmd_reg ? cmd_chunk : norm_chunk;
  assign c_name = sel_cmd_reg ? cmd_name : norm_name;
  assign c_ext = sel_cmd_reg ? cmd_ext : norm_ext;
  assign c_esc = sel_cmd_reg ? cmd_esc : norm_esc;
  assign c_id = sel_cmd_reg ? cmd_id : norm_id;
  assign sub_on = c_ext || c_name;
  assign norm_busy = norm_active;
  assign cmd_busy = cmd_active;

  // ----------------------------------------------------------------
  // Sub-header character generator
  // ----------------------------------------------------------------
  always_comb begin
    case (fld_reg)
      F_ID: dec_val = {{(LEN_W-7){1'b0}}, c_id};
      F_OFF: dec_val = c_off;
      default: dec_val = c_total;
    endcase
  end

  smhf_dec #(.WIDTH(LEN_W), .DIGITS(DEC_DIGITS)) u_dec (
    .value(dec_val), .ascii(dec_ascii), .msd(dec_msd)
  );

  assign name_idx = 3'(ci_reg - 4'h3);

  always_comb begin
    sub_char = CH_COLON;
    fld_next = fld_reg;
    ci_next = ci_reg + 4'h1;
    dpos_next = dpos_reg;
    sub_end = 1'b0;
    case (fld_reg)
      F_ID, F_OFF, F_TOT: begin
        if (ci_reg == 4'h0) begin
          sub_char = CH_COMMA;
          dpos_next = dec_msd;
        end else begin
          sub_char = dec_ascii[8*dpos_reg+:8];
          dpos_next = dpos_reg - 3'h1;
          if (dpos_reg == 3'h0) begin
            ci_next = 4'h0;
            // Total and name appear only in the first packet of a message.
            if (fld_reg == F_ID) begin
              fld_next = F_OFF;
            end else if (fld_reg == F_OFF && c_off == '0) begin
              fld_next = F_TOT;
            end else if (fld_reg == F_TOT && c_name) begin
              fld_next = F_NAME;
            end else begin
              fld_next = F_COLON;
            end
          end
        end
      end
      F_NAME: begin
        if (ci_reg == 4'h0) begin
          sub_char = CH_COMMA;
        end else if (ci_reg == 4'h1) begin
          sub_char = CH_NAME_TAG;
        end else if (ci_reg == 4'h2) begin
          sub_char = CH_EQUALS;
        end else begin
          sub_char = station_name[8*name_idx+:8];
        end
        if (ci_reg >= 4'h2 && ci_reg - 4'h2 == station_name_len) begin
          fld_next = F_COLON;
        end
      end
      default: sub_end = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Packet sequencer and output register
  // ----------------------------------------------------------------
  assign free = !ov_reg || out_ready;
  assign src_byte = sel_cmd_reg ? cmd_data : norm_data;
  assign src_take = sel_cmd_reg ? (crdy_reg && cmd_valid) : (nrdy_reg && norm_valid);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      sel_cmd_reg <= 1'b0;
      fld_reg <= F_ID;
      ci_reg <= 4'h0;
      dpos_reg <= 3'h0;
      rem_reg <= '0;
      ov_reg <= 1'b0;
      od_reg <= 8'h00;
      ol_reg <= 1'b0;
      hdr_reg <= 1'b0;
      nrdy_reg <= 1'b0;
      crdy_reg <= 1'b0;
    end else begin
      if (ov_reg && out_ready) begin
        ov_reg <= 1'b0;
      end
      case (st_reg)
        S_IDLE: begin
          fld_reg <= F_ID;
          ci_reg <= 4'h0;
          // Pending command responses win every packet boundary.
          if (cmd_active) begin
            sel_cmd_reg <= 1'b1;
            st_reg <= S_HDR;
          end else if (norm_active) begin
            sel_cmd_reg <= 1'b0;
            st_reg <= S_HDR;
          end
        end
        S_HDR: begin
          if (free) begin
            od_reg <= smhf_hdr_code(c_kind, c_ext);
            ov_reg <= 1'b1;
            hdr_reg <= 1'b1;
            ol_reg <= 1'b0;
            if (c_kind == K_ESC) begin
              st_reg <= S_ESC;
            end else if (sub_on) begin
              st_reg <= S_SUB;
            end else begin
              st_reg <= (c_chunk == '0) ? S_DONE : S_DATA;
              ol_reg <= (c_chunk == '0);
              rem_reg <= c_chunk;
            end
          end
        end
        S_ESC: begin
          if (free) begin
            od_reg <= c_esc;
            ov_reg <= 1'b1;
            hdr_reg <= 1'b0;
            if (sub_on) begin
              st_reg <= S_SUB;
            end else begin
              st_reg <= (c_chunk == '0) ? S_DONE : S_DATA;
              ol_reg <= (c_chunk == '0);
              rem_reg <= c_chunk;
            end
          end
        end
        S_SUB: begin
          if (free) begin
            od_reg <= sub_char;
            ov_reg <= 1'b1;
            hdr_reg <= 1'b0;
            fld_reg <= fld_next;
            ci_reg <= ci_next;
            dpos_reg <= dpos_next;
            if (sub_end) begin
              st_reg <= (c_chunk == '0) ? S_DONE : S_DATA;
              ol_reg <= (c_chunk == '0);
              rem_reg <= c_chunk;
            end
          end
        end
        S_DATA: begin
          // One byte in flight at a time: ready rises only with the slot free.
          if (src_take) begin
            od_reg <= src_byte;
            ov_reg <= 1'b1;
            hdr_reg <= 1'b0;
            ol_reg <= (rem_reg == 16'h0001);
            rem_reg <= rem_reg - 16'h0001;
            nrdy_reg <= 1'b0;
            crdy_reg <= 1'b0;
            if (rem_reg == 16'h0001) begin
              st_reg <= S_DONE;
            end
          end else if (!nrdy_reg && !crdy_reg && free) begin
            nrdy_reg <= !sel_cmd_reg;
            crdy_reg <= sel_cmd_reg;
          end
        end
        S_DONE: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  assign out_data = od_reg;
  assign out_valid = ov_reg;
  assign out_last = ol_reg;
  assign norm_ready = nrdy_reg;
  assign cmd_ready = crdy_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_hdr_printable;
    ov_reg && hdr_reg |-> (od_reg >= HC_PRINT_LO) && (od_reg <= HC_PRINT_HI);
  endproperty
  a_hdr_printable: assert property (p_hdr_printable) else $error("type byte unprintable");
  property p_hdr_code;
    ov_reg && hdr_reg && c_kind == K_CMD |-> od_reg == (HC_CMD | {7'h00, c_ext});
  endproperty
  a_hdr_code: assert property (p_hdr_code) else $error("wrong command type byte");
  property p_esc_follow;
    ov_reg && hdr_reg && c_kind == K_ESC && out_ready |=> ov_reg && od_reg == c_esc;
  endproperty
  a_esc_follow: assert property (p_esc_follow) else $error("escape not followed");
  property p_no_binary;
    ov_reg && hdr_reg |-> od_reg != HC_BINARY;
  endproperty
  a_no_binary: assert property (p_no_binary) else $error("reserved type byte sent");
  property p_ext_long;
    ov_reg && hdr_reg && c_kind <= K_FORCED && c_total > LEN_W'(PKT_MAX) |-> od_reg[0];
  endproperty
  a_ext_long: assert property (p_ext_long) else $error("long message not extended");
  property p_sub_follows;
    st_reg == S_HDR && free && c_kind != K_ESC && sub_on |=> st_reg == S_SUB ##[1:3] od_reg == CH_COMMA;
  endproperty
  a_sub_follows: assert property (p_sub_follows) else $error("sub-header missing");
  property p_id_wrap;
    msg_acc && id_ctr_reg == ID_LAST |=> id_ctr_reg == 7'h00;
  endproperty
  a_id_wrap: assert property (p_id_wrap) else $error("id did not wrap");
  property p_cmd_first;
    st_reg == S_IDLE && cmd_active && norm_active |=> sel_cmd_reg && st_reg == S_HDR;
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("command response delayed");
  property p_offset_order;
    st_reg == S_DONE && !sel_cmd_reg && norm_active |=>
      !norm_active || norm_off == $past(norm_off) + $past(norm_chunk);
  endproperty
  a_offset_order: assert property (p_offset_order) else $error("offset out of order");
  property p_colon_last;
    $past(st_reg) == S_SUB && st_reg != S_SUB |-> ov_reg && od_reg == CH_COLON;
  endproperty
  a_colon_last: assert property (p_colon_last) else $error("sub-header not closed");

  c_extended: cover property (ov_reg && hdr_reg && c_ext && out_ready);
  c_interleave: cover property (st_reg == S_HDR && sel_cmd_reg && norm_active && norm_off != '0);
  cov_name: cover property (st_reg == S_SUB && fld_reg == F_NAME && ci_reg == 4'h3);
  c_escape: cover property (st_reg == S_ESC && free);
endmodule

// ### verification/smhf_sink.sv
// Modem buffer model that collects framed packets and can stall.
`timescale 1ns/100ps
module smhf_sink (
  // Clock
  input wire logic clock,
  // Stream from the framer
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_last,
  output logic out_ready,
  // Stall on alternate cycles when set
  input wire logic slow
);
  string cur = "";
  string pkts[$];
  logic phase = 1'b0;
  initial out_ready = 1'b0;
  // Stalling makes the framer hold each byte across a refused cycle.
  always @(negedge clock) begin
    phase <= ~phase;
    out_ready <= slow ? phase : 1'b1;
  end
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready) begin
      cur = $sformatf("%s%c", cur, $isunknown(out_data) ? 8'h3f : out_data);
      if (out_last !== 1'b0) begin
        pkts.push_back(cur);
        cur = "";
      end
    end
  end
endmodule

// ### verification/smhf_framer_bench.sv
// Self-checking bench of the satellite message header framer.
`timescale 1ns/100ps
module smhf_framer_bench;
  import smhf_pkg::*;
  localparam int PM = 4;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic msg_start = 1'b0;
  smhf_kind_e msg_kind = K_SELF;
  logic [LEN_W-1:0] msg_total = '0;
  logic msg_name_en = 1'b0;
  logic [7:0] msg_esc = 8'h00;
  logic [8*NAME_MAX-1:0] station_name = {48'h0, 8'h42, 8'h41};
  logic [3:0] station_name_len = 4'h2;
  logic [7:0] norm_data = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic norm_valid = 1'b0;
  logic cmd_valid = 1'b0;
  logic norm_busy, cmd_busy, norm_ready, cmd_ready;
  logic [7:0] out_data;
  logic out_valid, out_last, out_ready;
  logic slow = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int n_idx = 0;
  int c_idx = 0;
  int next_id = 0;
  int cycles = 0;
  string last_got = "";

  smhf_framer #(.PKT_MAX(PM), .NAME_MAX(NAME_MAX)) i_smhf_framer (
    .clock(clock), .arst_n(arst_n), .msg_start(msg_start), .msg_kind(msg_kind),
    .msg_total(msg_total), .msg_name_en(msg_name_en), .msg_esc(msg_esc),
    .norm_busy(norm_busy), .cmd_busy(cmd_busy), .station_name(station_name),
    .station_name_len(station_name_len), .norm_data(norm_data), .norm_valid(norm_valid),
    .norm_ready(norm_ready), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .out_data(out_data), .out_valid(out_valid),
    .out_last(out_last), .out_ready(out_ready)
  );
  smhf_sink i_smhf_sink (
    .clock(clock), .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_ready(out_ready), .slow(slow)
  );

  // ----------------------------------------------------------------
  // Clock, payload sources and watchdog
  // ----------------------------------------------------------------
  always #5 clock = ~clock;
  // Payload byte value is 0x61 (reports) or 0x41 (commands) plus its offset in the message, so order errors show.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (norm_valid && norm_ready === 1'b1) begin
      n_idx <= n_idx + 1;
    end
    if (cmd_valid && cmd_ready === 1'b1) begin
      c_idx <= c_idx + 1;
    end
    if (cycles == 30000) begin
      n_fail++;
      close_out();
    end
  end
  always @(negedge clock) begin
    norm_data <= 8'h61 + n_idx[7:0];
    cmd_data <= 8'h41 + c_idx[7:0];
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic start_msg(input smhf_kind_e k, input int tot, input logic nm,
                           input logic [7:0] e);
    @(negedge clock);
    msg_kind = k;
    msg_total = tot[LEN_W-1:0];
    msg_name_en = nm;
    msg_esc = e;
    msg_start = 1'b1;
    @(negedge clock);
    msg_start = 1'b0;
  endtask

  function automatic string pkt(string t, int id, bit sub, bit first, int tot, bit nm,
                                int off, int n, logic [7:0] b);
    string s;
    s = t;
    if (sub) begin
      s = $sformatf("%s,%0d,%0d", s, id, off);
      if (first) begin
        s = $sformatf("%s,%0d", s, tot);
      end
      if (nm) begin
        s = {s, ",N=AB"};
      end
      s = {s, ":"};
    end
    for (int i = off; i < off + n; i++) begin
      s = $sformatf("%s%c", s, b + i);
    end
    return s;
  endfunction

  // Receiver side: payload is whatever follows the colon, or all after the type byte.
  function automatic string body(string s);
    for (int i = 0; i < s.len(); i++) begin
      if (s[i] == ":") begin
        return s.substr(i + 1, s.len() - 1);
      end
    end
    return s.substr(1, s.len() - 1);
  endfunction

  task automatic expect_pkt(input string e);
    string got;
    int w;
    w = 0;
    while (i_smhf_sink.pkts.size() == 0 && w < 400) begin
      @(negedge clock);
      w++;
    end
    got = (i_smhf_sink.pkts.size() > 0) ? i_smhf_sink.pkts.pop_front() : "none";
    last_got = got;
    total_checks++;
    if (got != e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wait_free();
    int w;
    w = 0;
    while ((norm_busy !== 1'b0 || cmd_busy !== 1'b0) && w < 400) begin
      @(negedge clock);
      w++;
    end
    if (w >= 400) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, {cmd_busy, norm_busy}, 2'h0);
    end
    next_id = next_id % 100;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_types();
    for (int k = 0; k < 5; k++) begin
      n_idx = 0;
      c_idx = 0;
      start_msg(smhf_kind_e'(k), 3, 1'b0, 8'h00);
      expect_pkt(pkt($sformatf("%c", 8'h30 + 2 * k), 0, 0, 0, 3, 0, 0, 3,
                     (k == 3) ? 8'h41 : 8'h61));
      next_id++;
      wait_free();
    end
    start_msg(K_USER, 0, 1'b0, 8'h00);
    expect_pkt("}");
    next_id++;
    wait_free();
    start_msg(K_ESC, 0, 1'b0, 8'h51);
    expect_pkt("~Q");
    next_id++;
    wait_free();
  endtask

  task automatic t_ext();
    slow = 1'b1;
    n_idx = 0;
    start_msg(K_SELF, PM, 1'b0, 8'h00);
    expect_pkt(pkt("0", 0, 0, 0, PM, 0, 0, PM, 8'h61));
    next_id++;
    wait_free();
    n_idx = 0;
    start_msg(K_ALARM_IN, PM + 2, 1'b0, 8'h00);
    expect_pkt(pkt("3", next_id, 1, 1, PM + 2, 0, 0, PM, 8'h61));
    expect_pkt(pkt("3", next_id, 1, 0, PM + 2, 0, PM, 2, 8'h61));
    next_id++;
    wait_free();
    slow = 1'b0;
  endtask

  task automatic t_name();
    n_idx = 0;
    start_msg(K_FORCED, 2, 1'b1, 8'h00);
    expect_pkt(pkt("8", next_id, 1, 1, 2, 1, 0, 2, 8'h61));
    next_id++;
    wait_free();
  endtask

  task automatic t_inter();
    string rx;
    n_idx = 0;
    c_idx = 0;
    start_msg(K_SELF, 2 * PM, 1'b0, 8'h00);
    start_msg(K_ALARM_OUT, 1, 1'b0, 8'h00);
    start_msg(K_CMD, PM + 1, 1'b0, 8'h00);
    total_checks++;
    if ({cmd_busy, norm_busy} !== 2'h3) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, {cmd_busy, norm_busy}, 2'h3);
    end
    expect_pkt(pkt("1", next_id, 1, 1, 2 * PM, 0, 0, PM, 8'h61));
    rx = body(last_got);
    expect_pkt(pkt("7", next_id + 1, 1, 1, PM + 1, 0, 0, PM, 8'h41));
    expect_pkt(pkt("7", next_id + 1, 1, 0, PM + 1, 0, PM, 1, 8'h41));
    expect_pkt(pkt("1", next_id, 1, 0, 2 * PM, 0, PM, PM, 8'h61));
    rx = {rx, body(last_got)};
    total_checks++;
    if (rx != "abcdefgh") begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, rx, "abcdefgh");
    end
    next_id += 2;
    wait_free();
  endtask

  task automatic t_wrap();
    for (int m = 0; m < 100; m++) begin
      start_msg(K_SELF, 0, 1'b1, 8'h00);
      expect_pkt(pkt("0", next_id, 1, 1, 0, 1, 0, 0, 8'h61));
      next_id++;
      wait_free();
    end
  endtask

  initial begin
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    norm_valid = 1'b1;
    cmd_valid = 1'b1;
    t_types();
    t_ext();
    t_name();
    t_inter();
    t_wrap();
    close_out();
  end
endmodule
